// ==== rtl/cnbr_setup.sv ====
// Node number and bit-rate setup logic of the drive's CAN node
`timescale 1ns/1ps
module cnbr_setup #(
  parameter logic [31:0] VENDOR_CODE = 32'h0000_0001,  // Arbitrary value
  parameter logic [31:0] PRODUCT_CODE = 32'h0000_0002, // Arbitrary value
  parameter logic [31:0] REVISION_CODE = 32'h0000_0003, // Arbitrary value
  parameter logic [31:0] SERIAL_CODE = 32'h0000_0004   // Arbitrary value
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // Received frame from the CAN controller, one-cycle strobe
  input wire logic rx_valid_i,
  input wire logic rx_ok_i,
  input wire logic [10:0] rx_id_i,
  input wire logic [63:0] rx_data_i,
  // Frame to transmit
  output logic tx_valid_o,
  output logic [10:0] tx_id_o,
  output logic [63:0] tx_data_o,
  // Bit timing to the CAN controller
  output logic [2:0] bit_rate_sel_o,
  // Nonvolatile storage: values loaded after reset, store pulse
  input wire logic nv_valid_i,
  input wire logic [7:0] nv_node_i,
  input wire logic [7:0] nv_rate_i,
  output logic nv_store_o,
  output logic [7:0] nv_node_o,
  output logic [7:0] nv_rate_o,
  // Network-management start and node state
  output logic nmt_start_o,
  output logic config_mode_o,
  output logic [7:0] node_number_o,
  // Register port
  input wire logic [15:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o
);

  // ------------------------------------------------------------
  // Frame decode
  // ------------------------------------------------------------
  function automatic logic [63:0] cnbr_reply(input logic [7:0] cmd, input logic [31:0] val);
    cnbr_reply = {24'h00_0000, val, cmd};
  endfunction

  // Range test shared by incoming assignments and the held number
  function automatic logic node_in_range(input logic [7:0] num);
    node_in_range = (num >= cnbr_pkg::NODE_MIN) && (num <= cnbr_pkg::NODE_MAX);
  endfunction

  // Candidates are tried round-robin; the last one wraps to the first
  function automatic logic [2:0] next_trial_rate(input logic [2:0] cur);
    next_trial_rate = (cur == cnbr_pkg::RATE_COUNT - 3'h1) ? 3'h0 : cur + 3'h1;
  endfunction

  // Selective addressing walks vendor, product, revision, serial in order
  typedef enum logic [3:0] {
    CNBR_SEL_IDLE = 4'b0001,
    CNBR_SEL_VENDOR = 4'b0010,
    CNBR_SEL_PRODUCT = 4'b0100,
    CNBR_SEL_REVISION = 4'b1000
  } cnbr_sel_t;

  cnbr_pkg::cnbr_state_t state;
  logic [7:0] node_number;
  logic [7:0] rate_code;
  logic [2:0] try_rate;
  logic [3:0] try_count;
  logic cfg_mode;
  cnbr_sel_t sel_state;
  cnbr_sel_t next_sel_state;
  logic [4:0] det_frames;
  logic nv_done;

  wire [7:0] cmd = rx_data_i[7:0];
  wire [7:0] arg8 = rx_data_i[15:8];
  wire [31:0] arg32 = {rx_data_i[39:32], rx_data_i[31:24], rx_data_i[23:16], rx_data_i[15:8]};
  wire detecting = (state == cnbr_pkg::CNBR_DETECT);
  wire lss_frame = rx_valid_i && rx_ok_i && !detecting &&
                   (rx_id_i == cnbr_pkg::ID_FROM_MASTER);
  wire node_ok = node_in_range(arg8);
  wire rate_ok = (arg8 <= cnbr_pkg::RATE_MAX_IDX) || (arg8 == cnbr_pkg::RATE_AUTO);
  wire is_global = lss_frame && (cmd == cnbr_pkg::CMD_SWITCH_GLOBAL);
  wire hit_vendor = lss_frame && (cmd == cnbr_pkg::CMD_SEL_VENDOR) && (arg32 == VENDOR_CODE);
  wire hit_product = lss_frame && (cmd == cnbr_pkg::CMD_SEL_PRODUCT) &&
                     (arg32 == PRODUCT_CODE);
  wire hit_revision = lss_frame && (cmd == cnbr_pkg::CMD_SEL_REVISION);
  wire hit_serial = lss_frame && (cmd == cnbr_pkg::CMD_SEL_SERIAL) && (arg32 == SERIAL_CODE);
  wire sel_done = hit_serial && (sel_state == CNBR_SEL_REVISION);
  wire set_node = lss_frame && cfg_mode && (cmd == cnbr_pkg::CMD_SET_NODE);
  wire set_rate = lss_frame && cfg_mode && (cmd == cnbr_pkg::CMD_SET_RATE);
  wire store = lss_frame && cfg_mode && (cmd == cnbr_pkg::CMD_STORE);
  wire node_valid = node_in_range(node_number);
  wire [2:0] fixed_rate = (rate_code <= cnbr_pkg::RATE_MAX_IDX) ? rate_code[2:0] : 3'h0;
  // Any error-free frame at the trial rate counts toward detection
  wire good_frame = rx_valid_i && rx_ok_i;
  wire bad_frame = rx_valid_i && !rx_ok_i;

  // ------------------------------------------------------------
  // Answer selection
  // ------------------------------------------------------------
  logic next_tx;
  logic [63:0] next_tx_data;
  always_comb begin
    next_tx = 1'b0;
    next_tx_data = 64'h0;
    // Configuration commands outside configuration mode stay silent
    if (lss_frame) begin
      unique case (cmd)
        cnbr_pkg::CMD_SEL_SERIAL: begin
          next_tx = sel_done;
          next_tx_data = cnbr_reply(cnbr_pkg::CMD_SEL_ANSWER, 32'h0);
        end
        cnbr_pkg::CMD_SET_NODE: begin
          next_tx = cfg_mode;
          next_tx_data = {48'h0, node_ok ? cnbr_pkg::ERR_OK : cnbr_pkg::ERR_RANGE, cmd};
        end
        cnbr_pkg::CMD_SET_RATE: begin
          next_tx = cfg_mode;
          next_tx_data = {48'h0, rate_ok ? cnbr_pkg::ERR_OK : cnbr_pkg::ERR_RANGE, cmd};
        end
        cnbr_pkg::CMD_STORE: begin
          next_tx = cfg_mode;
          next_tx_data = {48'h0, cnbr_pkg::ERR_OK, cmd};
        end
        cnbr_pkg::CMD_INQ_VENDOR: begin
          next_tx = cfg_mode;
          next_tx_data = cnbr_reply(cmd, VENDOR_CODE);
        end
        cnbr_pkg::CMD_INQ_PRODUCT: begin
          next_tx = cfg_mode;
          next_tx_data = cnbr_reply(cmd, PRODUCT_CODE);
        end
        cnbr_pkg::CMD_INQ_REVISION: begin
          next_tx = cfg_mode;
          next_tx_data = cnbr_reply(cmd, REVISION_CODE);
        end
        cnbr_pkg::CMD_INQ_SERIAL: begin
          next_tx = cfg_mode;
          next_tx_data = cnbr_reply(cmd, SERIAL_CODE);
        end
        cnbr_pkg::CMD_INQ_NODE: begin
          next_tx = cfg_mode;
          next_tx_data = {48'h0, node_number, cmd};
        end
        default: begin
          next_tx = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_valid_o <= 1'b0;
      tx_data_o <= 64'h0;
    end else begin
      tx_valid_o <= next_tx;
      // Data holds between answers so a slow reader still finds it
      if (next_tx) begin
        tx_data_o <= next_tx_data;
      end
    end
  end
  assign tx_id_o = cnbr_pkg::ID_FROM_NODE;

  // ------------------------------------------------------------
  // Configuration mode and selective address tracking
  // ------------------------------------------------------------
  wire sel_cmd = lss_frame && (cmd >= cnbr_pkg::CMD_SEL_VENDOR) &&
                 (cmd <= cnbr_pkg::CMD_SEL_SERIAL);
  // A vendor, product or serial mismatch or an out-of-order part restarts the walk; the revision value is not compared
  always_comb begin
    next_sel_state = sel_state;
    if (hit_vendor) begin
      next_sel_state = CNBR_SEL_VENDOR;
    end else if (sel_cmd) begin
      unique case (sel_state)
        CNBR_SEL_IDLE: begin
          next_sel_state = CNBR_SEL_IDLE;
        end
        CNBR_SEL_VENDOR: begin
          next_sel_state = hit_product ? CNBR_SEL_PRODUCT : CNBR_SEL_IDLE;
        end
        CNBR_SEL_PRODUCT: begin
          next_sel_state = hit_revision ? CNBR_SEL_REVISION : CNBR_SEL_IDLE;
        end
        CNBR_SEL_REVISION: begin
          next_sel_state = CNBR_SEL_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_mode <= 1'b0;
      sel_state <= CNBR_SEL_IDLE;
    end else begin
      if (is_global) begin
        cfg_mode <= arg8[0];
      end else if (sel_done) begin
        cfg_mode <= 1'b1;
      end
      sel_state <= next_sel_state;
    end
  end

  // ------------------------------------------------------------
  // Node number, rate code, start-up sequence
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      node_number <= cnbr_pkg::NODE_UNCONF;
      rate_code <= cnbr_pkg::RATE_AUTO;
      nv_done <= 1'b0;
      state <= cnbr_pkg::CNBR_LSS_INIT;
      try_rate <= 3'h0;
      try_count <= 4'h0;
      nmt_start_o <= 1'b0;
    end else begin
      nmt_start_o <= 1'b0;
      // Stored values take priority over a frame in the same cycle
      if (!nv_done && nv_valid_i) begin
        nv_done <= 1'b1;
        node_number <= nv_node_i;
        rate_code <= nv_rate_i;
        if (nv_rate_i == cnbr_pkg::RATE_AUTO) begin
          state <= cnbr_pkg::CNBR_DETECT;
        end
      end else begin
        if (set_node && node_ok) begin
          node_number <= arg8;
        end
        if (set_rate && rate_ok) begin
          rate_code <= arg8;
        end
        unique case (state)
          cnbr_pkg::CNBR_DETECT: begin
            // Three clean frames confirm a candidate; an error moves on
            if (good_frame) begin
              if (try_count == cnbr_pkg::FRAMES_PER_RATE - 4'h1) begin
                state <= cnbr_pkg::CNBR_LSS_INIT;
              end else begin
                try_count <= try_count + 4'h1;
              end
            end else if (bad_frame) begin
              try_count <= 4'h0;
              try_rate <= next_trial_rate(try_rate);
            end
          end
          cnbr_pkg::CNBR_LSS_INIT: begin
            // Configuration mode holds the node here until the master leaves it
            if (nv_done && node_valid && !cfg_mode) begin
              state <= cnbr_pkg::CNBR_RUN;
              nmt_start_o <= 1'b1;
            end
          end
          cnbr_pkg::CNBR_RUN: begin
            state <= cnbr_pkg::CNBR_RUN;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nv_store_o <= 1'b0;
    end else begin
      nv_store_o <= store;
    end
  end
  assign nv_node_o = node_number;
  assign nv_rate_o = rate_code;
  assign bit_rate_sel_o = (rate_code == cnbr_pkg::RATE_AUTO) ? try_rate : fixed_rate;
  assign config_mode_o = cfg_mode;
  assign node_number_o = node_number;

  // ------------------------------------------------------------
  // Detection frame budget
  // ------------------------------------------------------------
  // Saturates at the budget, so software can tell a slow lock from a dead bus
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      det_frames <= 5'h0;
    end else if (detecting && rx_valid_i && (det_frames != cnbr_pkg::DETECT_FRAME_LIMIT)) begin
      det_frames <= det_frames + 5'h1;
    end
  end

  // ------------------------------------------------------------
  // Register port, all read-only; writes are ignored
  // ------------------------------------------------------------
  // Status: frames seen [10:6], state [5:3], cfg [2], node valid [1], loaded [0]
  wire [31:0] status_word = {21'h0, det_frames, state, cfg_mode, node_valid, nv_done};
  wire [31:0] rd_mux = (reg_addr_i == cnbr_pkg::OFS_RATE_READBACK) ? {24'h0, rate_code} :
                       (reg_addr_i == cnbr_pkg::OFS_NODE_NUMBER) ? {24'h0, node_number} :
                       (reg_addr_i == cnbr_pkg::OFS_STATUS) ? status_word : 32'h0;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= 32'h0;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rd_mux;
    end
  end
endmodule

// ==== rtl/cnbr_pkg.sv ====
// Package: constants for the node number and bit-rate setup block
package cnbr_pkg;
  localparam logic [10:0] ID_FROM_MASTER = 11'h7e5;
  localparam logic [10:0] ID_FROM_NODE = 11'h7e4;
  localparam logic [7:0] NODE_UNCONF = 8'hff;
  localparam logic [7:0] NODE_MIN = 8'h01;
  localparam logic [7:0] NODE_MAX = 8'h7f;
  localparam logic [7:0] RATE_AUTO = 8'hff;
  localparam logic [7:0] RATE_MAX_IDX = 8'h04;
  localparam logic [3:0] FRAMES_PER_RATE = 4'h3;
  localparam logic [2:0] RATE_COUNT = 3'h5;
  localparam logic [4:0] DETECT_FRAME_LIMIT = 5'h18;
  // Register offsets (index of the readback object and own status words)
  localparam logic [15:0] OFS_RATE_READBACK = 16'h2400;
  localparam logic [15:0] OFS_NODE_NUMBER = 16'h2401;
  localparam logic [15:0] OFS_STATUS = 16'h2402;
  // Layer-setting command codes
  localparam logic [7:0] CMD_SWITCH_GLOBAL = 8'h04;
  localparam logic [7:0] CMD_SEL_VENDOR = 8'h40;
  localparam logic [7:0] CMD_SEL_PRODUCT = 8'h41;
  localparam logic [7:0] CMD_SEL_REVISION = 8'h42;
  localparam logic [7:0] CMD_SEL_SERIAL = 8'h43;
  localparam logic [7:0] CMD_SEL_ANSWER = 8'h44;
  localparam logic [7:0] CMD_SET_NODE = 8'h11;
  localparam logic [7:0] CMD_SET_RATE = 8'h13;
  localparam logic [7:0] CMD_STORE = 8'h17;
  localparam logic [7:0] CMD_INQ_VENDOR = 8'h5a;
  localparam logic [7:0] CMD_INQ_PRODUCT = 8'h5b;
  localparam logic [7:0] CMD_INQ_REVISION = 8'h5c;
  localparam logic [7:0] CMD_INQ_SERIAL = 8'h5d;
  localparam logic [7:0] CMD_INQ_NODE = 8'h5e;
  localparam logic [7:0] ERR_OK = 8'h00;
  localparam logic [7:0] ERR_RANGE = 8'h01;
  typedef enum logic [2:0] {
    CNBR_DETECT = 3'b001,
    CNBR_LSS_INIT = 3'b010,
    CNBR_RUN = 3'b100
  } cnbr_state_t;
endpackage

// ==== bench/cnbr_props.sv ====
// Port checker for the node number and bit-rate setup block
`timescale 1ns/1ps
module cnbr_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic rx_valid_i,
  input wire logic rx_ok_i,
  input wire logic [10:0] rx_id_i,
  input wire logic [63:0] rx_data_i,
  input wire logic tx_valid_o,
  input wire logic [10:0] tx_id_o,
  input wire logic [2:0] bit_rate_sel_o,
  input wire logic nv_store_o,
  input wire logic [7:0] nv_rate_o,
  input wire logic nmt_start_o,
  input wire logic config_mode_o,
  input wire logic [7:0] node_number_o,
  input wire logic [15:0] reg_addr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ---
  // Port relations
  // ---
  sequence store_req;
    config_mode_o && rx_valid_i && rx_ok_i && rx_id_i == 11'h7e5 && rx_data_i[7:0] == 8'h17;
  endsequence
  sequence store_done;
    nv_store_o && tx_valid_o;
  endsequence
  store_pulse_a: assert property (
    store_req |=> store_done) else $error("store not done");
  tx_id_a: assert property (
    tx_valid_o |-> tx_id_o == 11'h7e4) else $error("bad answer id");
  foreign_id_a: assert property (
    rx_valid_i && rx_id_i != 11'h7e5 |=> !tx_valid_o) else $error("foreign id answered");
  node_range_a: assert property (
    node_number_o inside {[8'h01:8'h7f], 8'hff}) else $error("node out of range");
  rate_apply_a: assert property (
    nv_rate_o <= 8'h04 |-> bit_rate_sel_o == nv_rate_o[2:0]) else $error("rate not applied");
  start_gate_a: assert property (
    nmt_start_o |-> $past(!config_mode_o && node_number_o inside {[8'h01:8'h7f]}))
    else $error("bad start");
  first_state_a: assert property (
    $fell(rst_i) |-> node_number_o == 8'hff && nv_rate_o == 8'hff && !config_mode_o)
    else $error("bad state after reset");
  rd_rate_a: assert property (
    reg_rd_i && reg_addr_i == 16'h2400 |=> reg_rdata_o == {24'h0, $past(nv_rate_o)})
    else $error("bad rate readback");
  rd_hole_a: assert property (
    reg_rd_i && !(reg_addr_i inside {[16'h2400:16'h2402]}) |=> reg_rdata_o == 32'h0)
    else $error("unmapped read not zero");
endmodule
bind cnbr_setup cnbr_props cnbr_props_i (.clk_i, .rst_i, .rx_valid_i, .rx_ok_i, .rx_id_i,
  .rx_data_i, .tx_valid_o, .tx_id_o, .bit_rate_sel_o, .nv_store_o, .nv_rate_o, .nmt_start_o,
  .config_mode_o, .node_number_o, .reg_addr_i, .reg_rd_i, .reg_rdata_o);

// ==== bench/cnbr_lssm.sv ====
// Layer-setting master model on the far side of the frame ports
`timescale 1ns/1ps
module cnbr_lssm (
  input wire logic clk_i,
  output logic rx_valid_o = 1'b0,
  output logic rx_ok_o = 1'b0,
  output logic [10:0] rx_id_o = 11'h0,
  output logic [63:0] rx_data_o = 64'h0,
  input wire logic tx_valid_i,
  input wire logic [63:0] tx_data_i
);
  int ans_cnt = 0;
  logic [63:0] ans_data = 64'h0;
  // ---
  // Frame driver and answer capture
  // ---
  // Released id and data lines show the inverse so a stale frame never reads as fresh
  task automatic send(input logic ok, input logic [10:0] id, input logic [63:0] data);
    @(posedge clk_i);
    rx_valid_o <= 1'b1;
    rx_ok_o <= ok;
    rx_id_o <= id;
    rx_data_o <= data;
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    rx_id_o <= ~id;
    rx_data_o <= ~data;
    @(posedge clk_i);
    #1;
  endtask
  always @(posedge clk_i) begin
    if (tx_valid_i === 1'b1) begin
      ans_cnt <= ans_cnt + 1;
      ans_data <= tx_data_i;
    end
  end
endmodule

// ==== bench/cnbr_setup_test.sv ====
// Self-checking bench for the node number and bit-rate setup block
`timescale 1ns/1ps
module cnbr_setup_test;
  localparam logic [31:0] VEND = 32'h0000_0a11; // Arbitrary value
  localparam logic [31:0] PROD = 32'h0000_0b22; // Arbitrary value
  localparam logic [31:0] SER = 32'h0000_0c33; // Arbitrary value
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic nv_valid_i = 1'b0;
  logic [7:0] nv_i = 8'hff;
  logic [15:0] reg_addr_i = 16'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [31:0] d;
  logic [31:0] seed = 32'h0000_0bd9;
  logic rx_valid_i, rx_ok_i, tx_valid_o, nv_store_o, nmt_start_o, config_mode_o;
  logic [10:0] rx_id_i, tx_id_o;
  logic [63:0] rx_data_i, tx_data_o;
  logic [2:0] bit_rate_sel_o;
  logic [7:0] nv_node_o, nv_rate_o, node_number_o;
  logic [31:0] reg_rdata_o;
  int error_cnt = 0;
  int cmp_count = 0;
  int stores = 0;
  int starts = 0;
  int node_m = 255;
  int rate_m = 255;
  int r0, n;
  int nq[$] = '{0, 128, 254, 5, 127, 1};
  // ---
  // Harness
  // ---
  cnbr_setup #(.VENDOR_CODE(VEND), .PRODUCT_CODE(PROD), .SERIAL_CODE(SER)) cnbr_setup_i (
    .clk_i, .rst_i, .rx_valid_i, .rx_ok_i, .rx_id_i, .rx_data_i, .tx_valid_o, .tx_id_o,
    .tx_data_o, .bit_rate_sel_o, .nv_valid_i, .nv_node_i(nv_i), .nv_rate_i(nv_i),
    .nv_store_o, .nv_node_o, .nv_rate_o, .nmt_start_o, .config_mode_o, .node_number_o,
    .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o);
  cnbr_lssm cnbr_lssm_i (.clk_i, .rx_valid_o(rx_valid_i), .rx_ok_o(rx_ok_i),
    .rx_id_o(rx_id_i), .rx_data_o(rx_data_i), .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o));
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    stores += (nv_store_o === 1'b1);
    starts += (nmt_start_o === 1'b1);
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    d = reg_rdata_o;
  endtask
  task automatic lss(input logic [7:0] cmd, input logic [31:0] arg);
    n = cnbr_lssm_i.ans_cnt;
    cnbr_lssm_i.send(1'b1, 11'h7e5, {24'h0, arg, cmd});
  endtask
  initial begin
    #100000;
    error_cnt++;
    final_report();
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    nv_valid_i <= 1'b1;
    rd(16'h2400);
    chk("rate reg", d, rate_m);
    chk("node", node_number_o, node_m);
    // Error frame moves the trial rate; three good frames lock it
    r0 = bit_rate_sel_o;
    cnbr_lssm_i.send(1'b0, 11'h7e5, 64'h0);
    chk("trial rate", bit_rate_sel_o, (r0 + 1) % 5);
    lss(8'h04, 32'h1);
    chk("busy answer", cnbr_lssm_i.ans_cnt - n, 0);
    chk("busy cfg", config_mode_o, 1'b0);
    repeat (2) begin
      seed = xs(seed);
      cnbr_lssm_i.send(1'b1, {1'b0, seed[9:0]}, {seed, ~seed});
    end
    chk("found rate", bit_rate_sel_o, (r0 + 1) % 5);
    rd(16'h2402);
    chk("status", d, 32'h0000_0111);
    lss(8'h04, 32'h1);
    chk("cfg on", config_mode_o, 1'b1);
    chk("no start", starts, 0);
    foreach (nq[i]) begin
      lss(8'h11, nq[i]);
      if (nq[i] >= 1 && nq[i] <= 127)
        node_m = nq[i];
      chk("node ans", cnbr_lssm_i.ans_data[15:0], {7'h0, node_m != nq[i], 8'h11});
      chk("node", node_number_o, node_m);
    end
    for (int c = 0; c < 5; c++) begin
      lss(8'h13, c);
      rate_m = c;
      chk("rate sel", bit_rate_sel_o, rate_m);
      rd(16'h2400);
      chk("rate reg", d, rate_m);
    end
    lss(8'h5e, 32'h0);
    chk("inq node", cnbr_lssm_i.ans_data[15:0], {node_m[7:0], 8'h5e});
    lss(8'h5a, 32'h0);
    chk("inq vendor", cnbr_lssm_i.ans_data[39:0], {VEND, 8'h5a});
    lss(8'h17, 32'h0);
    chk("stores", stores, 1);
    chk("nv node", nv_node_o, node_m);
    chk("nv rate", nv_rate_o, rate_m);
    // Writes to the read-only object are dropped
    seed = xs(seed);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= 16'h2400;
    reg_wdata_i <= seed;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    rd(16'h2400);
    chk("ro reg", d, rate_m);
    rd({4'h1, seed[11:0]});
    chk("unmapped", d, 32'h0);
    lss(8'h04, 32'h0);
    for (int k = 0; k < 8 && starts == 0; k++)
      @(posedge clk_i);
    chk("start", starts, 1);
    // Wrong serial first, then the full address with revision zero
    for (int k = 0; k < 2; k++) begin
      lss(8'h40, VEND);
      lss(8'h41, PROD);
      lss(8'h42, 32'h0);
      lss(8'h43, SER ^ {31'h0, k == 0});
      chk("sel answer", cnbr_lssm_i.ans_cnt - n, k);
      chk("sel cfg", config_mode_o, k);
    end
    chk("sel code", cnbr_lssm_i.ans_data[7:0], 8'h44);
    final_report();
  end
endmodule
